// ===== shared/scope_trig_pkg.sv
// scope trigger unit package: register map, field positions, codes
// assumes one ref_clk domain and a 16-bit register port
package scope_trig_pkg;
  localparam int DW = 16;
  localparam int AW = 6;
  localparam int NUNIT = 4;
  // address decode: addr[GLB_BIT] picks globals, addr[4:3] the unit
  localparam int GLB_BIT = 5;
  localparam int UNIT_LSB = 3;
  localparam logic [2:0] REG_CFG = 3'h0;
  localparam logic [2:0] REG_QUAL = 3'h1;
  localparam logic [2:0] REG_TH1 = 3'h2;
  localparam logic [2:0] REG_TH2 = 3'h3;
  localparam logic [2:0] REG_PW = 3'h4;
  localparam logic [AW-1:0] GLB_CTRL = 6'h20;
  localparam logic [AW-1:0] GLB_TPER = 6'h21;
  localparam logic [AW-1:0] GLB_CHRONO = 6'h22;
  localparam logic [AW-1:0] GLB_CAPT = 6'h23;
  localparam logic [AW-1:0] GLB_STAT = 6'h24;
  // trigger_unit_config fields
  localparam int ACT_TIMER_CLEAR = 2;
  localparam int ACT_TIMER_CAPT = 3;
  localparam int ACT_OUTPUT_SET = 4;
  localparam int ACT_RECORD_OR_CHAIN = 5;
  localparam int CHAIN_SEL = 7;
  localparam int SRC_LSB = 8;
  localparam int EVT_LSB = 11;
  localparam int ENA_LSB = 0;
  // host_control_byte_one fields
  localparam int CTRL_SHOT = 0;
  localparam int CTRL_OUT_CLR = 1;
  localparam int OUTPUT_SET_PERMIT_BIT = 2;
  localparam int CTRL_REC_CLR = 3;
  localparam int STAT_DOUT = 0;
  localparam int STAT_REC = 1;
  // reset values
  localparam logic [DW-1:0] CFG_RST = 16'h0000;
  localparam logic [DW-1:0] TH_RST = 16'h03E8;
  localparam logic [DW-1:0] PW_RST = 16'h0064;
  localparam logic [DW-1:0] ZERO_W = 16'h0000;
  localparam logic [DW-1:0] ONE_W = 16'h0001;
  localparam logic [DW-1:0] MAX_W = 16'hFFFF;
  typedef enum logic [2:0] {
    SRC_SHOT = 3'b000, SRC_TIMER = 3'b001, SRC_DIG = 3'b010,
    SRC_AN1 = 3'b011, SRC_AN2 = 3'b100
  } src_e;
  typedef enum logic [2:0] {
    EVT_RISE = 3'b000, EVT_FALL = 3'b001, EVT_POS_LONG = 3'b010,
    EVT_POS_SHORT = 3'b011, EVT_NEG_LONG = 3'b100, EVT_NEG_SHORT = 3'b101
  } evt_e;
  typedef enum logic [2:0] {
    ENA_ALWAYS = 3'b000, ENA_DIG_HIGH = 3'b001, ENA_DIG_LOW = 3'b010,
    ENA_A1_ABOVE = 3'b011, ENA_A1_BELOW = 3'b100, ENA_A2_ABOVE = 3'b101,
    ENA_A2_BELOW = 3'b110
  } ena_e;
endpackage : scope_trig_pkg

// ===== rtl/scope_trigger_unit_logic.sv
// trigger units of a one- or two-channel scope input: source, event,
// enable gate and action for each unit, plus chronometer and timer.
// assumes samples and the trigger pin are synchronous to ref_clk and
// that sampleStrobe marks one cycle per sample period.
//
// The address map and the strobed register port were chosen for this implementation.

// Overview of operation
// - shot source fires on host shot command
// - timer source fires at programmed period
// - digital source follows trigger input pin
// - analog one source uses channel one samples
// - channel two source only on two-channel
// - rising edge fires on upward threshold crossing
// - falling edge fires on downward threshold crossing
// - four pulse-width modes compare against width
// - detected pulse ANDed with enable condition
// - always enabled forwards every pulse
// - digital high gate needs pin high
// - digital low gate needs pin low
// - analog one above second threshold gate
// - analog one below second threshold gate
// - channel two gates only on two-channel
// - timer clear action zeroes, chronometer resumes
// - capture action latches chronometer value
// - output set needs host permit bit
// - unit one chain arms unit two
// - two-channel chain continues to units three, four
module scope_trigger_unit_logic
  import scope_trig_pkg::*;
#(
  parameter bit TWO_CHANNEL = 1'b1
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // register port
  input wire logic [AW-1:0] regAddr,
  input wire logic [DW-1:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [DW-1:0] regRdData,
  // samples and trigger pin
  input wire logic sampleStrobe,
  input wire logic [DW-1:0] ch1Sample,
  input wire logic [DW-1:0] ch2Sample,
  input wire logic trigPin,
  // actions
  output logic digitalOut,
  output logic recordStart,
  output logic [DW-1:0] chronometer
);

  // signed compare used by the analog sources and gates
  function automatic logic isAbove(input logic [DW-1:0] v, input logic [DW-1:0] th);
    isAbove = $signed(v) > $signed(th);
  endfunction : isAbove

  function automatic logic isBelow(input logic [DW-1:0] v, input logic [DW-1:0] th);
    isBelow = $signed(v) < $signed(th);
  endfunction : isBelow

  logic [DW-1:0] cfg_q [NUNIT];
  logic [DW-1:0] qual_q [NUNIT];
  logic [DW-1:0] th1_q [NUNIT];
  logic [DW-1:0] th2_q [NUNIT];
  logic [DW-1:0] pw_q [NUNIT];
  logic [DW-1:0] tPer_q;
  logic [DW-1:0] tCnt_q;
  logic [DW-1:0] chrono_q;
  logic [DW-1:0] capt_q;
  logic [DW-1:0] rdData_q;
  logic permit_q;
  logic dout_q;
  logic recSticky_q;
  logic recStart_q;
  logic [1:0] unitIdx;
  logic unitSel;
  logic ctrlWr;
  logic shotPulse;
  logic timerTick;
  logic [NUNIT-1:0] detVec;
  logic [NUNIT-1:0] qualVec;
  logic [NUNIT-1:0] chainOut;
  logic [NUNIT-1:0] prevAboveVec;
  logic anyClear;
  logic anyCapt;
  logic anySet;
  logic anyRec;

  // register decode
  assign unitIdx = regAddr[UNIT_LSB+1:UNIT_LSB];
  assign unitSel = !regAddr[GLB_BIT];
  assign ctrlWr = regWr && (regAddr == GLB_CTRL);
  assign shotPulse = ctrlWr && regWrData[CTRL_SHOT];

  // per-unit configuration registers
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < NUNIT; i++) begin
        cfg_q[i] <= CFG_RST;
        qual_q[i] <= CFG_RST;
        th1_q[i] <= TH_RST;
        th2_q[i] <= TH_RST;
        pw_q[i] <= PW_RST;
      end
    end else if (regWr && unitSel) begin
      case (regAddr[2:0])
        REG_CFG: cfg_q[unitIdx] <= regWrData;
        REG_QUAL: qual_q[unitIdx] <= regWrData;
        REG_TH1: th1_q[unitIdx] <= regWrData;
        REG_TH2: th2_q[unitIdx] <= regWrData;
        REG_PW: pw_q[unitIdx] <= regWrData;
        default: ;
      endcase
    end
  end

  // global control: timer period and output permit
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      tPer_q <= ZERO_W;
      permit_q <= 1'b0;
    end else begin
      if (regWr && regAddr == GLB_TPER) tPer_q <= regWrData;
      if (ctrlWr) permit_q <= regWrData[OUTPUT_SET_PERMIT_BIT];
    end
  end

  // periodic timer, period in ref_clk cycles, zero stops it
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      tCnt_q <= ZERO_W;
    end else if (tPer_q == ZERO_W || timerTick) begin
      tCnt_q <= ZERO_W;
    end else begin
      tCnt_q <= tCnt_q + ONE_W;
    end
  end
  assign timerTick = (tPer_q != ZERO_W) && (tCnt_q == tPer_q - ONE_W);

  // one trigger unit per index; units three and four need two channels
  for (genvar u = 0; u < NUNIT; u++) begin : gUnit
    logic present;
    logic [2:0] src;
    logic [2:0] evt;
    logic [2:0] ena;
    logic [DW-1:0] srcVal;
    logic srcOk;
    logic above;
    logic strobeAbove;
    logic prevAbove_q;
    logic [DW-1:0] width_q;
    logic armed_q;
    logic chained;
    logic rise;
    logic fall;
    logic evtHit;
    logic gateOpen;
    logic armOk;

    assign present = (u < 2) || TWO_CHANNEL;
    assign src = cfg_q[u][SRC_LSB+2:SRC_LSB];
    assign evt = cfg_q[u][EVT_LSB+2:EVT_LSB];
    assign ena = qual_q[u][ENA_LSB+2:ENA_LSB];

    // source selection
    always_comb begin
      srcVal = ch1Sample;
      srcOk = 1'b1;
      case (src)
        SRC_AN2: begin
          srcVal = ch2Sample;
          srcOk = TWO_CHANNEL;
        end
        SRC_AN1: srcVal = ch1Sample;
        default: srcVal = ch1Sample;
      endcase
    end
    assign above = (src == SRC_DIG) ? trigPin : isAbove(srcVal, th1_q[u]);
    assign strobeAbove = above && srcOk;

    // level history and run length, one step per sample
    always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
        prevAbove_q <= 1'b0;
        width_q <= ZERO_W;
      end else if (sampleStrobe) begin
        prevAbove_q <= strobeAbove;
        if (strobeAbove != prevAbove_q) width_q <= ONE_W;
        else if (width_q != MAX_W) width_q <= width_q + ONE_W;
      end
    end

    // event detector
    assign rise = sampleStrobe && !prevAbove_q && strobeAbove;
    assign fall = sampleStrobe && prevAbove_q && !strobeAbove;
    always_comb begin
      case (evt)
        EVT_RISE: evtHit = rise;
        EVT_FALL: evtHit = fall;
        EVT_POS_LONG: evtHit = fall && (width_q > pw_q[u]);
        EVT_POS_SHORT: evtHit = fall && (width_q < pw_q[u]);
        EVT_NEG_LONG: evtHit = rise && (width_q > pw_q[u]);
        EVT_NEG_SHORT: evtHit = rise && (width_q < pw_q[u]);
        default: evtHit = 1'b0;
      endcase
    end
    always_comb begin
      case (src)
        SRC_SHOT: detVec[u] = shotPulse;
        SRC_TIMER: detVec[u] = timerTick;
        default: detVec[u] = evtHit && srcOk;
      endcase
    end

    // enable condition on the second gate input
    always_comb begin
      case (ena)
        ENA_ALWAYS: gateOpen = 1'b1;
        ENA_DIG_HIGH: gateOpen = trigPin;
        ENA_DIG_LOW: gateOpen = !trigPin;
        ENA_A1_ABOVE: gateOpen = isAbove(ch1Sample, th2_q[u]);
        ENA_A1_BELOW: gateOpen = isBelow(ch1Sample, th2_q[u]);
        ENA_A2_ABOVE: gateOpen = TWO_CHANNEL && isAbove(ch2Sample, th2_q[u]);
        ENA_A2_BELOW: gateOpen = TWO_CHANNEL && isBelow(ch2Sample, th2_q[u]);
        default: gateOpen = 1'b0;
      endcase
    end

    // chain arming from the previous unit
    if (u == 0) begin : gHead
      assign chained = 1'b0;
      assign armOk = 1'b1;
    end else begin : gLink
      assign chained = cfg_q[u-1][ACT_RECORD_OR_CHAIN] && cfg_q[u-1][CHAIN_SEL];
      assign armOk = !chained || armed_q || chainOut[u-1];
    end
    always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
        armed_q <= 1'b0;
      end else if (qualVec[u]) begin
        armed_q <= 1'b0;
      end else if (u > 0 && chained && chainOut[(u > 0) ? u-1 : 0]) begin
        armed_q <= 1'b1;
      end
    end

    assign qualVec[u] = present && detVec[u] && gateOpen && armOk;
    assign chainOut[u] = qualVec[u] && cfg_q[u][ACT_RECORD_OR_CHAIN] && cfg_q[u][CHAIN_SEL];
    assign prevAboveVec[u] = prevAbove_q;
  end

  // action dispatch over all units
  always_comb begin
    anyClear = 1'b0;
    anyCapt = 1'b0;
    anySet = 1'b0;
    anyRec = 1'b0;
    for (int i = 0; i < NUNIT; i++) begin
      anyClear = anyClear || (qualVec[i] && cfg_q[i][ACT_TIMER_CLEAR]);
      anyCapt = anyCapt || (qualVec[i] && cfg_q[i][ACT_TIMER_CAPT]);
      anySet = anySet || (qualVec[i] && cfg_q[i][ACT_OUTPUT_SET]);
      anyRec = anyRec || (qualVec[i] && cfg_q[i][ACT_RECORD_OR_CHAIN]
               && !cfg_q[i][CHAIN_SEL]);
    end
  end

  // free-running chronometer with clear
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) chrono_q <= ZERO_W;
    else if (anyClear) chrono_q <= ZERO_W;
    else chrono_q <= chrono_q + ONE_W;
  end

  // capture of the chronometer
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) capt_q <= ZERO_W;
    else if (anyCapt) capt_q <= chrono_q;
  end

  // digital output, set wins over a software clear
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) dout_q <= 1'b0;
    else if (anySet && permit_q) dout_q <= 1'b1;
    else if (ctrlWr && regWrData[CTRL_OUT_CLR]) dout_q <= 1'b0;
  end

  // recording start pulse and its sticky status
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      recStart_q <= 1'b0;
      recSticky_q <= 1'b0;
    end else begin
      recStart_q <= anyRec;
      if (anyRec) recSticky_q <= 1'b1;
      else if (ctrlWr && regWrData[CTRL_REC_CLR]) recSticky_q <= 1'b0;
    end
  end

  // read data, valid only in the cycle after the strobe
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rdData_q <= ZERO_W;
    end else if (!regRd) begin
      rdData_q <= ZERO_W;
    end else if (unitSel) begin
      case (regAddr[2:0])
        REG_CFG: rdData_q <= cfg_q[unitIdx];
        REG_QUAL: rdData_q <= qual_q[unitIdx];
        REG_TH1: rdData_q <= th1_q[unitIdx];
        REG_TH2: rdData_q <= th2_q[unitIdx];
        REG_PW: rdData_q <= pw_q[unitIdx];
        default: rdData_q <= ZERO_W;
      endcase
    end else begin
      case (regAddr)
        GLB_CTRL: rdData_q <= {13'h0000, permit_q, 2'b00};
        GLB_TPER: rdData_q <= tPer_q;
        GLB_CHRONO: rdData_q <= chrono_q;
        GLB_CAPT: rdData_q <= capt_q;
        GLB_STAT: rdData_q <= {14'h0000, recSticky_q, dout_q};
        default: rdData_q <= ZERO_W;
      endcase
    end
  end

  assign regRdData = rdData_q;
  assign digitalOut = dout_q;
  assign recordStart = recStart_q;
  assign chronometer = chrono_q;

  // checks
  a_shot_fires_unit: assert property (@(posedge ref_clk) disable iff (!reset_n)
    shotPulse && cfg_q[0][SRC_LSB+2:SRC_LSB] == SRC_SHOT |-> detVec[0])
    else $error("shot command did not fire unit one");
  a_timer_tick_spacing: assert property (@(posedge ref_clk) disable iff (!reset_n)
    timerTick && tPer_q > ONE_W && $stable(tPer_q) |=> !timerTick)
    else $error("timer ticks back to back");
  a_rise_needs_crossing: assert property (@(posedge ref_clk) disable iff (!reset_n)
    detVec[0] && cfg_q[0][SRC_LSB+2:SRC_LSB] == SRC_AN1
    && cfg_q[0][EVT_LSB+2:EVT_LSB] == EVT_RISE
    |-> sampleStrobe && !prevAboveVec[0] && isAbove(ch1Sample, th1_q[0]))
    else $error("rising event without upward crossing");
  a_gate_needs_detect: assert property (@(posedge ref_clk) disable iff (!reset_n)
    qualVec[0] |-> detVec[0])
    else $error("qualified pulse without detection");
  a_dig_high_gate: assert property (@(posedge ref_clk) disable iff (!reset_n)
    qualVec[0] && qual_q[0][2:0] == ENA_DIG_HIGH |-> trigPin)
    else $error("digital high gate passed with pin low");
  a_dig_low_gate: assert property (@(posedge ref_clk) disable iff (!reset_n)
    qualVec[0] && qual_q[0][2:0] == ENA_DIG_LOW |-> !trigPin)
    else $error("digital low gate passed with pin high");
  a_clear_then_count: assert property (@(posedge ref_clk) disable iff (!reset_n)
    anyClear ##1 !anyClear |=> chrono_q == ONE_W)
    else $error("chronometer did not clear and resume");
  a_capture_value: assert property (@(posedge ref_clk) disable iff (!reset_n)
    anyCapt |=> capt_q == $past(chrono_q))
    else $error("capture latched wrong count");
  a_out_needs_permit: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !dout_q && !permit_q |=> !dout_q)
    else $error("digital output set without permit");
  a_units_absent: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !TWO_CHANNEL |-> qualVec[3:2] == 2'b00)
    else $error("units three or four active on one channel");

endmodule : scope_trigger_unit_logic

// ===== tb/scope_host_model.sv
// fieldbus coupler model: writes and reads 16-bit words on the register port
// assumes nothing else drives the port; every change lands on a rising edge
module scope_host_model
  import scope_trig_pkg::*;
(
  // clock
  input wire logic ref_clk,
  // register port
  output logic [AW-1:0] regAddr,
  output logic [DW-1:0] regWrData,
  output logic regWr,
  output logic regRd,
  input wire logic [DW-1:0] regRdData
);
  timeunit 1ns;
  timeprecision 1ps;

  // idle bus from time zero
  initial begin
    regAddr = '0;
    regWrData = '0;
    regWr = 1'b0;
    regRd = 1'b0;
  end

  // one write cycle; raised at an edge, held through the taking edge
  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge ref_clk);
    regWr <= 1'b0;
    regWrData <= ~d; // released data must not look valid
    #1;
  endtask : wr

  // one read cycle; data is taken in the cycle after the strobe
  task automatic rd(input logic [AW-1:0] a, output logic [DW-1:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge ref_clk);
    regRd <= 1'b0;
    #1;
    d = regRdData;
  endtask : rd
endmodule : scope_host_model

// ===== tb/test_scope_trigger_unit_logic.sv
// self-checking bench for the trigger unit logic, two-channel build
// assumes the host model drives the register port and samples come from here
module test_scope_trigger_unit_logic;
  import scope_trig_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic sampleStrobe = 1'b0;
  logic [DW-1:0] ch1Sample = '0;
  logic [DW-1:0] ch2Sample = '0;
  logic trigPin = 1'b0;
  logic [AW-1:0] regAddr;
  logic [DW-1:0] regWrData;
  logic regWr;
  logic regRd;
  logic [DW-1:0] regRdData;
  logic digitalOut;
  logic recordStart;
  logic [DW-1:0] chronometer;
  int mismatches = 0;
  int tests_run = 0;
  int cycles = 0;
  logic [DW-1:0] rv;
  logic [DW-1:0] p;

  // 125 MHz clock
  always #4 ref_clk = ~ref_clk;

  scope_host_model host (.ref_clk(ref_clk), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData));

  scope_trigger_unit_logic #(.TWO_CHANNEL(1'b1)) dut (.ref_clk(ref_clk), .reset_n(reset_n),
    .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
    .regRdData(regRdData), .sampleStrobe(sampleStrobe), .ch1Sample(ch1Sample),
    .ch2Sample(ch2Sample), .trigPin(trigPin), .digitalOut(digitalOut),
    .recordStart(recordStart), .chronometer(chronometer));

  // compare one value and count it
  task automatic check(input logic [DW-1:0] seen, input logic [DW-1:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  function automatic logic [AW-1:0] ua(input int u, input logic [2:0] k);
    return AW'(u * 8) + AW'(k);
  endfunction : ua

  // one sample strobe on a channel, then optionally judge recordStart
  task automatic smp(input bit ch2, input logic [DW-1:0] v, input bit chk, input bit exp);
    @(posedge ref_clk);
    if (ch2) ch2Sample <= v;
    else ch1Sample <= v;
    sampleStrobe <= 1'b1;
    @(posedge ref_clk);
    sampleStrobe <= 1'b0;
    #1;
    if (chk) check(DW'(recordStart), DW'(exp));
  endtask : smp

  task automatic final_report;
    $display("checks %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : final_report

  // hang guard
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      final_report();
    end
  end

  task automatic t_reset;
    host.rd(ua(0, REG_TH1), rv);
    check(rv, TH_RST);
    host.rd(ua(1, REG_PW), rv);
    check(rv, PW_RST);
    host.rd(ua(0, REG_CFG), rv);
    check(rv, CFG_RST);
    host.rd(6'h30, rv);
    check(rv, ZERO_W); // unmapped reads as zero
    $display("test reset values done");
  endtask : t_reset

  task automatic t_capture;
    host.wr(ua(0, REG_CFG), 16'h000C); // shot source, clear and capture
    p = chronometer + ONE_W; // count at the edge that takes the shot
    host.wr(GLB_CTRL, 16'h0001);
    check(chronometer, ZERO_W);
    host.rd(GLB_CAPT, rv);
    check(rv, p);
    $display("test shot capture done");
  endtask : t_capture

  task automatic t_output;
    host.wr(ua(0, REG_CFG), 16'h0010);
    host.wr(GLB_CTRL, 16'h0001);
    check(DW'(digitalOut), ZERO_W);
    host.wr(GLB_CTRL, 16'h0004); // permit bit from the host
    host.rd(GLB_CTRL, rv);
    check(rv, 16'h0004);
    host.wr(GLB_CTRL, 16'h0005);
    check(DW'(digitalOut), ONE_W);
    host.rd(GLB_STAT, rv);
    check(rv, 16'h0001);
    host.wr(GLB_CTRL, 16'h0002);
    check(DW'(digitalOut), ZERO_W);
    $display("test output set done");
  endtask : t_output

  task automatic t_edges;
    host.wr(ua(0, REG_CFG), 16'h0320); // analog one, rising, record
    smp(0, 16'h0000, 1, 0);
    smp(0, 16'h07D0, 1, 1);
    smp(0, 16'h07D0, 1, 0);
    smp(0, 16'h0000, 1, 0);
    host.wr(ua(0, REG_CFG), 16'h0B20); // falling
    smp(0, 16'h07D0, 1, 0);
    smp(0, 16'hFF9C, 1, 1);
    host.wr(ua(0, REG_CFG), 16'h0220); // digital pin source, rising, record
    @(posedge ref_clk);
    trigPin <= 1'b1;
    smp(0, 16'h0000, 1, 1);
    @(posedge ref_clk);
    trigPin <= 1'b0;
    smp(0, 16'h0000, 1, 0);
    $display("test edges done");
  endtask : t_edges

  task automatic t_enable;
    bit e;
    host.wr(ua(0, REG_CFG), 16'h0420); // analog two, rising, record
    for (int v = 0; v < 2; v++) begin
      for (int q = 0; q < 8; q++) begin
        case (q)
          0: e = 1;
          1, 3: e = (v == 1);
          2, 4: e = (v == 0);
          5: e = 1;
          default: e = 0;
        endcase
        host.wr(ua(0, REG_QUAL), DW'(q));
        @(posedge ref_clk);
        trigPin <= (v == 1);
        ch1Sample <= (v == 1) ? 16'h07D0 : 16'h0000;
        smp(1, 16'h0000, 1, 0);
        smp(1, 16'h07D0, 1, e);
      end
    end
    host.wr(ua(0, REG_QUAL), ZERO_W);
    $display("test enable gate done");
  endtask : t_enable

  task automatic t_width;
    logic [DW-1:0] hi;
    logic [DW-1:0] lo;
    bit e;
    host.wr(ua(0, REG_PW), 16'h0003);
    for (int m = 2; m < 6; m++) begin
      host.wr(ua(0, REG_CFG), 16'h0320 | DW'(m << 11));
      hi = (m < 4) ? 16'h07D0 : 16'hFF9C;
      lo = (m < 4) ? 16'hFF9C : 16'h07D0;
      for (int l = 2; l < 6; l += 3) begin
        e = (m % 2 == 0) ? (l > 3) : (l < 3);
        repeat (2) smp(0, lo, 0, 0);
        repeat (l) smp(0, hi, 0, 0);
        smp(0, lo, 1, e);
      end
    end
    $display("test pulse width done");
  endtask : t_width

  task automatic t_timer;
    int n;
    host.wr(ua(0, REG_CFG), 16'h0120); // timer source, record
    host.wr(GLB_TPER, 16'h000A);
    for (int k = 0; k < 2; k++) begin
      n = 0;
      do begin
        @(posedge ref_clk);
        #1;
        n++;
      end while (recordStart !== 1'b1 && n < 40);
    end
    check(DW'(n), 16'h000A);
    host.wr(GLB_TPER, ZERO_W);
    $display("test timer done");
  endtask : t_timer

  task automatic t_chain;
    host.wr(ua(1, REG_CFG), 16'h00A0);
    host.wr(ua(2, REG_CFG), 16'h00A0);
    host.wr(ua(3, REG_CFG), 16'h0020);
    host.wr(ua(0, REG_CFG), 16'h00A0);
    host.wr(ua(0, REG_QUAL), 16'h0007); // head gate shut, chain stays unarmed
    host.wr(GLB_CTRL, 16'h0001);
    check(DW'(recordStart), ZERO_W);
    host.wr(ua(0, REG_QUAL), ZERO_W);
    host.wr(GLB_CTRL, 16'h0001);
    check(DW'(recordStart), ONE_W);
    host.rd(GLB_STAT, rv);
    check(rv, 16'h0002);
    host.wr(GLB_CTRL, 16'h0008); // clear the record sticky flag
    host.rd(GLB_STAT, rv);
    check(rv, ZERO_W);
    $display("test chain done");
  endtask : t_chain

  // main sequence
  initial begin
    repeat (10) @(posedge ref_clk);
    reset_n <= 1'b1;
    @(posedge ref_clk);
    #1;
    t_reset();
    t_capture();
    t_output();
    t_edges();
    t_enable();
    t_width();
    t_timer();
    t_chain();
    final_report();
  end
endmodule : test_scope_trigger_unit_logic
